// ==== sensor_link_pkg.sv ====
package sensor_link_pkg;

    localparam int          CLK_HZ            = 40_000_000;
    localparam int          CONV_PERIOD_MS    = 60;
    localparam int          CONV_CYCLES       = CONV_PERIOD_MS * (CLK_HZ / 1000);
    localparam int          TIMEOUT_US        = 22_500;
    localparam int          TIMEOUT_CYCLES    = TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int          SCL_QUARTER_CYCLES = 100;

    localparam logic [3:0]  SLAVE_ADDR_HI     = 4'h9;

    localparam logic [2:0]  PTR_TEMP          = 3'h0;
    localparam logic [2:0]  PTR_CONFIG        = 3'h1;
    localparam logic [2:0]  PTR_HYST          = 3'h2;
    localparam logic [2:0]  PTR_TRIP          = 3'h3;
    localparam logic [2:0]  PTR_ONESHOT       = 3'h4;
    localparam logic [2:0]  PTR_RESET         = 3'h0;

    localparam int          CFG_ONESHOT_BIT   = 5;
    localparam int          CFG_FAULT_LSB     = 3;
    localparam int          CFG_POL_BIT       = 2;
    localparam int          CFG_INT_BIT       = 1;
    localparam int          CFG_SHDN_BIT      = 0;
    localparam logic [7:0]  CFG_RESET         = 8'h00;
    localparam logic [15:0] HYST_RESET        = 16'h4b00;
    localparam logic [15:0] TRIP_RESET        = 16'h5000;
    localparam logic [15:0] TEMP_RESET        = 16'h0000;
    localparam logic [15:0] LIMIT_MASK        = 16'hfff0;

    localparam logic [7:0]  REG_CMD           = 8'h00;
    localparam logic [7:0]  REG_TXDATA        = 8'h04;
    localparam logic [7:0]  REG_RXDATA        = 8'h08;
    localparam logic [7:0]  REG_STATUS        = 8'h0c;
    localparam int          CMD_READ_BIT      = 7;
    localparam int          CMD_COUNT_LSB     = 8;
    localparam int          STAT_BUSY_BIT     = 0;
    localparam int          STAT_NACK_BIT     = 1;

endpackage : sensor_link_pkg

// ==== sensor_link_if.sv ====
`timescale 1ns/1ps
interface sensor_link_if;
    logic scl;
    logic m_sda_out;
    logic m_sda_oe;
    logic d_sda_out;
    logic d_sda_oe;
    logic sda;

    // Open drain: a driver can only pull low, pull-up otherwise
    assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

    modport controller (output scl, output m_sda_out, output m_sda_oe, input sda);
    modport sensor     (input scl, output d_sda_out, output d_sda_oe, input sda);
endinterface : sensor_link_if

// ==== sensor_link_controller.sv ====
`timescale 1ns/1ps
module sensor_link_controller
    import sensor_link_pkg::*;
#(
    parameter int QUARTER = SCL_QUARTER_CYCLES
)(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    sensor_link_if.controller link
);
    if (QUARTER < 8) begin : bad_quarter
        $error("QUARTER must leave room for the sensor's input synchronisers");
    end

    typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} master_state_t;

    localparam int QW = $clog2(QUARTER);

    master_state_t   state;
    logic [QW-1:0]   q_cnt;
    logic [1:0]      phase;
    logic [1:0]      byte_num;
    logic [3:0]      bit_idx;
    logic [6:0]      cmd_addr;
    logic            cmd_read;
    logic [1:0]      cmd_count;
    logic [23:0]     tx_bytes;
    logic [15:0]     rx_data;
    logic            nack;
    logic            scl;
    logic            sda_oe;
    logic [1:0]      sda_sync;

    wire       sda_s     = sda_sync[1];
    wire       tick      = q_cnt == QW'(QUARTER - 1);
    wire       setup     = psel & ~penable;
    wire       access    = psel & penable;
    wire       hit_cmd   = paddr == REG_CMD;
    wire       hit_tx    = paddr == REG_TXDATA;
    wire       mapped    = hit_cmd | hit_tx | (paddr == REG_RXDATA) | (paddr == REG_STATUS);
    wire       busy      = state != M_IDLE;
    wire       go        = access & pwrite & hit_cmd & ~busy;
    wire       reading   = cmd_read & (byte_num != 2'd0);
    wire       last_byte = byte_num == cmd_count;
    wire [7:0] cur_byte  = (byte_num == 2'd0) ? {cmd_addr, cmd_read}
                         : tx_bytes[8 * (byte_num - 2'd1) +: 8];
    wire [2:0] bit_pos   = 3'(4'd7 - bit_idx);

    // Always ready; a command while busy is refused with an error
    assign pready        = 1'b1;
    assign pslverr       = access & (~mapped | (pwrite & hit_cmd & busy));
    assign link.scl      = scl;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe = sda_oe;

    always_ff @(posedge clk_sys)
        sda_sync <= {sda_sync[0], link.sda};

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            prdata <= 32'h0000_0000;
        else if (setup)
            prdata <= hit_cmd ? {22'h0, cmd_count, cmd_read, cmd_addr}
                    : hit_tx ? {8'h00, tx_bytes}
                    : (paddr == REG_RXDATA) ? {16'h0000, rx_data}
                    : (paddr == REG_STATUS) ? {30'h0, nack, busy} : 32'h0000_0000;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            tx_bytes <= 24'h000000;
        else if (access & pwrite & hit_tx)
            tx_bytes <= pwdata[23:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state     <= M_IDLE;
            q_cnt     <= '0;
            phase     <= 2'd0;
            byte_num  <= 2'd0;
            bit_idx   <= 4'd0;
            cmd_addr  <= 7'h00;
            cmd_read  <= 1'b0;
            cmd_count <= 2'd0;
            rx_data   <= 16'h0000;
            nack      <= 1'b0;
            scl       <= 1'b1;
            sda_oe    <= 1'b0;
        end
        else if (go)
        begin
            // One direction per transaction; a new start for each
            state     <= M_START;
            cmd_addr  <= pwdata[6:0];
            cmd_read  <= pwdata[CMD_READ_BIT];
            cmd_count <= pwdata[CMD_COUNT_LSB +: 2];
            q_cnt     <= '0;
            phase     <= 2'd0;
            byte_num  <= 2'd0;
            bit_idx   <= 4'd0;
            rx_data   <= 16'h0000;
            nack      <= 1'b0;
        end
        else if (busy)
        begin
            q_cnt <= tick ? '0 : q_cnt + 1'b1;
            if (tick)
            begin
                phase <= phase + 2'd1;
                unique case (state)
                    M_START:
                    begin
                        // Data falls while clock is high
                        if (phase == 2'd1) sda_oe <= 1'b1;
                        if (phase == 2'd2) scl <= 1'b0;
                        if (phase == 2'd3) state <= M_BIT;
                    end
                    M_BIT:
                    begin
                        // Data moves only in the low half of the clock
                        if (phase == 2'd0)
                            sda_oe <= (bit_idx < 4'd8) ? (~reading & ~cur_byte[bit_pos])
                                    : (reading & ~last_byte);
                        if (phase == 2'd1) scl <= 1'b1;
                        if (phase == 2'd2 && bit_idx < 4'd8 && reading)
                            rx_data <= {rx_data[14:0], sda_s};
                        if (phase == 2'd2 && bit_idx == 4'd8 && !reading && sda_s)
                            nack <= 1'b1;
                        if (phase == 2'd3)
                        begin
                            scl <= 1'b0;
                            // Nine clocks per byte, ninth is the acknowledge
                            if (bit_idx == 4'd8)
                            begin
                                bit_idx <= 4'd0;
                                if (nack | last_byte)
                                    state <= M_STOP;
                                else
                                    byte_num <= byte_num + 2'd1;
                            end
                            else
                                bit_idx <= bit_idx + 4'd1;
                        end
                    end
                    M_STOP:
                    begin
                        if (phase == 2'd0) sda_oe <= 1'b1;
                        if (phase == 2'd1) scl <= 1'b1;
                        if (phase == 2'd2) sda_oe <= 1'b0;
                        if (phase == 2'd3) state <= M_IDLE;
                    end
                    default: state <= M_IDLE;
                endcase
            end
        end
    end

endmodule : sensor_link_controller

// ==== temp_sensor_slave.sv ====
`timescale 1ns/1ps
// Behaviour
// - Continuous conversion every 60 ms by default
// - One-shot mode: one conversion per write
// - Fault field selects 1, 2, 4, 6 faults
// - Polarity bit selects alert active level
// - Mode bit selects comparator or latched alert
// - Shutdown bit stops conversions, keeps interface
// - Hysteresis limit resets to +75 degrees
// - Alert when temperature reaches trip limit
// - Limits move upper byte first, low nibble empty
// - Address 1001 plus three select pins
// - Select pins sampled all the time
// - SDA low 22.5 ms aborts transaction
// - No timeout while SDA stays high
// - Master opens with start condition
// - Address MSB first, then direction, acknowledged
// - Direction 0 writes, 1 reads
// - Nine clocks per byte including acknowledge
// - SDA stable while SCL high, rise means stop
// - Master ends read with no-ack and stop
// - One direction per transaction
// - Pointer selects register, resets to zero
// - Faults must be consecutive to count
// - Comparator: set at trip, clear below hysteresis
// - Latched: any read clears, rearm below hysteresis
module temp_sensor_slave
    import sensor_link_pkg::*;
#(
    parameter int CONV_CYC    = CONV_CYCLES,
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
)(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    sensor_link_if.sensor    link,
    input  wire logic [15:0] temp_value,
    input  wire logic        addr_select_bit2,
    input  wire logic        addr_select_bit1,
    input  wire logic        addr_select_bit0,
    output logic             over_temp_output,
    output logic             sensor_powered,
    output logic             conv_strobe
);
    if (CONV_CYC < 2 || TIMEOUT_CYC < 2) begin : bad_counts
        $error("Conversion and timeout counts must be at least 2");
    end

    typedef enum logic [1:0] {SL_IDLE, SL_ADDR, SL_WRITE, SL_READ} slave_state_t;

    localparam int CW = $clog2(CONV_CYC);
    localparam int TW = $clog2(TIMEOUT_CYC);

    function automatic logic [2:0] faults_needed(input logic [1:0] code);
        unique case (code)
            2'd0: faults_needed = 3'd1;
            2'd1: faults_needed = 3'd2;
            2'd2: faults_needed = 3'd4;
            2'd3: faults_needed = 3'd6;
        endcase
    endfunction : faults_needed

    slave_state_t  state;
    logic [1:0]    scl_sync;
    logic [1:0]    sda_sync;
    logic [2:0]    asel_meta;
    logic [2:0]    asel;
    logic          scl_d;
    logic          sda_d;
    logic [3:0]    bit_cnt;
    logic          ack_phase;
    logic [7:0]    shreg;
    logic [7:0]    tx;
    logic          sda_drive;
    logic [1:0]    byte_idx;
    logic          rd_dir;
    logic [2:0]    pointer;
    logic [7:0]    mode_configuration;
    logic [15:0]   hysteresis_limit;
    logic [15:0]   trip_limit;
    logic [15:0]   stored_temp;
    logic [7:0]    limit_hi;
    logic [TW-1:0] timeout_cnt;
    logic [CW-1:0] conv_cnt;
    logic          oneshot_pending;
    logic [2:0]    fault_cnt;
    logic          alert_active;
    logic          rearm;

    wire scl_s      = scl_sync[1];
    wire sda_s      = sda_sync[1];
    wire scl_rise   = scl_s & ~scl_d;
    wire scl_fall   = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
    wire [6:0] own_addr = {SLAVE_ADDR_HI, asel};
    wire byte_end   = scl_fall & ~ack_phase & (bit_cnt == 4'd8);
    wire wr_done    = byte_end & (state == SL_WRITE);
    wire rd_start   = byte_end & (state == SL_ADDR) & (shreg[7:1] == own_addr) & shreg[0];
    wire timeout_hit = timeout_cnt == TW'(TIMEOUT_CYC - 1);

    wire shdn       = mode_configuration[CFG_SHDN_BIT];
    wire oneshot_md = mode_configuration[CFG_ONESHOT_BIT];
    wire continuous = ~shdn & ~oneshot_md;
    wire oneshot_wr = wr_done & (byte_idx == 2'd0) & (shreg[2:0] == PTR_ONESHOT);
    wire conv_tick  = continuous ? (conv_cnt == CW'(CONV_CYC - 1)) : oneshot_pending;

    wire [15:0] sample     = temp_value & LIMIT_MASK;
    wire        fault      = $signed(sample) >= $signed(trip_limit);
    wire        below_hyst = $signed(sample) < $signed(hysteresis_limit);
    wire [2:0]  next_fault_cnt = !fault ? 3'd0
                             : (fault_cnt == 3'd6) ? 3'd6 : fault_cnt + 3'd1;
    wire        over = fault & (next_fault_cnt >= faults_needed(
                           mode_configuration[CFG_FAULT_LSB +: 2]));

    // Select bytes 0 and 1 (high then low) of the pointed register; one-shot reads as zero
    wire [15:0] rd_word = (pointer == PTR_TEMP)   ? stored_temp
                        : (pointer == PTR_CONFIG) ? {mode_configuration, mode_configuration}
                        : (pointer == PTR_HYST)   ? hysteresis_limit
                        : (pointer == PTR_TRIP)   ? trip_limit : 16'h0000;
    wire [7:0]  rd_byte = byte_idx[0] ? rd_word[7:0] : rd_word[15:8];

    assign link.d_sda_out = 1'b0;
    assign link.d_sda_oe  = sda_drive;

    // Pins come from outside; only the second stage is used
    always_ff @(posedge clk_sys)
    begin
        scl_sync  <= {scl_sync[0], link.scl};
        sda_sync  <= {sda_sync[0], link.sda};
        asel_meta <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
        asel      <= asel_meta;
        scl_d     <= scl_s;
        sda_d     <= sda_s;
    end

    // Only a stuck-low SDA counts; any SCL edge is activity too
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || state == SL_IDLE || sda_s || scl_rise || scl_fall)
            timeout_cnt <= '0;
        else if (!timeout_hit)
            timeout_cnt <= timeout_cnt + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state     <= SL_IDLE;
            bit_cnt   <= 4'd0;
            ack_phase <= 1'b0;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            sda_drive <= 1'b0;
            byte_idx  <= 2'd0;
            rd_dir    <= 1'b0;
        end
        else if (start_cond)
        begin
            state     <= SL_ADDR;
            bit_cnt   <= 4'd0;
            ack_phase <= 1'b0;
            byte_idx  <= 2'd0;
            sda_drive <= 1'b0;
        end
        else if (stop_cond || timeout_hit)
        begin
            state     <= SL_IDLE;
            ack_phase <= 1'b0;
            sda_drive <= 1'b0;
        end
        else if (state != SL_IDLE)
        begin
            if (scl_rise && !ack_phase)
            begin
                shreg   <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'd1;
            end
            else if (scl_rise && state == SL_READ && sda_s)
                state <= SL_IDLE;
            if (scl_fall && ack_phase)
            begin
                ack_phase <= 1'b0;
                bit_cnt   <= 4'd0;
                if (state == SL_READ || (state == SL_ADDR && rd_dir))
                begin
                    tx        <= rd_byte;
                    sda_drive <= ~rd_byte[7];
                    byte_idx  <= byte_idx + 2'd1;
                end
                else
                    sda_drive <= 1'b0;
                if (state == SL_ADDR)
                    state <= rd_dir ? SL_READ : SL_WRITE;
            end
            else if (byte_end)
            begin
                ack_phase <= 1'b1;
                unique case (state)
                    SL_ADDR:
                    begin
                        if (shreg[7:1] == own_addr)
                        begin
                            sda_drive <= 1'b1;
                            rd_dir    <= shreg[0];
                        end
                        else
                            state <= SL_IDLE;
                    end
                    SL_WRITE:
                    begin
                        sda_drive <= 1'b1;
                        if (byte_idx != 2'd3)
                            byte_idx <= byte_idx + 2'd1;
                    end
                    default: sda_drive <= 1'b0;
                endcase
            end
            else if (scl_fall && state == SL_READ)
            begin
                tx        <= {tx[6:0], 1'b0};
                sda_drive <= ~tx[6];
            end
        end
    end

    // First byte of a write is the pointer; limits take high then low byte
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            pointer            <= PTR_RESET;
            mode_configuration <= CFG_RESET;
            hysteresis_limit   <= HYST_RESET;
            trip_limit         <= TRIP_RESET;
            limit_hi           <= 8'h00;
        end
        else if (wr_done)
        begin
            if (byte_idx == 2'd0)
                pointer <= shreg[2:0];
            else if (byte_idx == 2'd1 && pointer == PTR_CONFIG)
                mode_configuration <= shreg;
            else if (byte_idx == 2'd1)
                limit_hi <= shreg;
            else if (byte_idx == 2'd2 && pointer == PTR_HYST)
                hysteresis_limit <= {limit_hi, shreg} & LIMIT_MASK;
            else if (byte_idx == 2'd2 && pointer == PTR_TRIP)
                trip_limit <= {limit_hi, shreg} & LIMIT_MASK;
        end
    end

    // Shutdown stops all conversions, one-shot too; the serial port and alert output keep working
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !continuous)
            conv_cnt <= '0;
        else
            conv_cnt <= conv_tick ? '0 : conv_cnt + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || shdn || !oneshot_md)
            oneshot_pending <= 1'b0;
        else if (oneshot_wr)
            oneshot_pending <= 1'b1;
        else if (conv_tick)
            oneshot_pending <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            stored_temp    <= TEMP_RESET;
            conv_strobe    <= 1'b0;
            sensor_powered <= 1'b0;
        end
        else
        begin
            conv_strobe    <= conv_tick;
            sensor_powered <= continuous | oneshot_pending;
            if (conv_tick)
                stored_temp <= sample;
        end
    end

    // Comparator output survives shutdown; a set beats a read-clear
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            fault_cnt    <= 3'd0;
            alert_active <= 1'b0;
            rearm        <= 1'b1;
        end
        else
        begin
            if (mode_configuration[CFG_INT_BIT] && rd_start)
                alert_active <= 1'b0;
            if (conv_tick)
            begin
                fault_cnt <= next_fault_cnt;
                if (!mode_configuration[CFG_INT_BIT])
                begin
                    if (over)
                        alert_active <= 1'b1;
                    else if (below_hyst)
                        alert_active <= 1'b0;
                end
                else if (over && rearm)
                begin
                    alert_active <= 1'b1;
                    rearm        <= 1'b0;
                end
                else if (below_hyst)
                    rearm <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            over_temp_output <= 1'b1;
        else
            over_temp_output <= mode_configuration[CFG_POL_BIT] ? alert_active
                                                                : ~alert_active;
    end

endmodule : temp_sensor_slave

// ==== temp_sensor_config_limits_serial_slave_chk.sv ====
`timescale 1ns/1ps
module temp_sensor_config_limits_serial_slave_chk #(
    parameter int TIMEOUT_CYC = 300
)(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic d_sda_out,
    input wire logic d_sda_oe
);
    logic        scl_q;
    logic [31:0] low_cnt;
    always_ff @(posedge clk_sys) scl_q <= scl;
    always_ff @(posedge clk_sys)
        low_cnt <= (!d_sda_oe || scl != scl_q) ? 32'h0 : low_cnt + 32'h1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_release_scl_low: assert property ($fell(d_sda_oe) |-> !scl && !$past(scl))
        else $error("sensor released sda while scl high");
    a_drive_scl_low: assert property ($rose(d_sda_oe) |-> !scl [*8])
        else $error("sensor drove sda too near scl high");
    a_start_quiet: assert property (scl && $fell(sda) |-> !d_sda_oe [*8])
        else $error("sensor active right after start");
    a_stop_quiet: assert property (scl && $rose(sda) |=> !d_sda_oe [*8])
        else $error("sensor active right after stop");
    a_open_drain: assert property (!m_sda_out && !d_sda_out)
        else $error("sda driven high");
    a_timeout_bound: assert property (low_cnt <= TIMEOUT_CYC)
        else $error("sensor held sda past timeout");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    a_sda_high_stable: assert property (scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe))
        else $error("sda moved by sensor while scl high");
    c_start: cover property (scl && $fell(sda));
    c_ack: cover property ($rose(d_sda_oe));
    c_stop: cover property (scl && $rose(sda));
endmodule : temp_sensor_config_limits_serial_slave_chk

// ==== temp_sensor_config_limits_serial_slave_tb_top.sv ====
`timescale 1ns/1ps
module temp_sensor_config_limits_serial_slave_tb_top;
    import sensor_link_pkg::*;
    typedef struct packed {logic [23:0] tx; logic [1:0] wn; logic [1:0] rn; logic [15:0] exp;} row_t;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] temp_value = 16'h0000;
    logic [2:0]  asel = 3'h0;
    logic        over_temp_output;
    logic        sensor_powered;
    logic        conv_strobe;
    int          num_errors = 0;
    int          n_tests = 0;
    int          n_conv = 0;
    int          nf [4] = '{1, 2, 4, 6};
    logic [15:0] rx;
    logic        nk;
    row_t        rows [6];
    wire  [6:0]  dev = {SLAVE_ADDR_HI, asel};
    sensor_link_if link();
    sensor_link_controller #(.QUARTER(10)) sensor_link_controller_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    temp_sensor_slave #(.CONV_CYC(200), .TIMEOUT_CYC(300)) temp_sensor_slave_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .link(link), .temp_value(temp_value), .addr_select_bit2(asel[2]),
        .addr_select_bit1(asel[1]), .addr_select_bit0(asel[0]),
        .over_temp_output(over_temp_output), .sensor_powered(sensor_powered),
        .conv_strobe(conv_strobe));
    temp_sensor_config_limits_serial_slave_chk #(.TIMEOUT_CYC(300)) chk_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .scl(link.scl), .sda(link.sda), .m_sda_out(link.m_sda_out),
        .m_sda_oe(link.m_sda_oe), .d_sda_out(link.d_sda_out), .d_sda_oe(link.d_sda_oe));
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (conv_strobe === 1'b1) n_conv <= n_conv + 1;
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task xfer(input logic [6:0] a, input logic r, input logic [1:0] n, input logic [23:0] t);
        logic [31:0] q;
        apb(1'b1, REG_TXDATA, {8'h00, t}, q);
        apb(1'b1, REG_CMD, {22'h0, n, r, a}, q);
        for (int i = 0; i < 5000; i++)
        begin
            apb(1'b0, REG_STATUS, 32'h0, q);
            if (q[STAT_BUSY_BIT] === 1'b0) break;
        end
        nk = q[STAT_NACK_BIT];
        apb(1'b0, REG_RXDATA, 32'h0, q);
        rx = q[15:0];
    endtask : xfer
    task wait_conv;
        do @(posedge clk_sys); while (conv_strobe !== 1'b1);
    endtask : wait_conv
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end
    initial
    begin
        int k;
        logic pol;
        rows[0] = '{24'h000002, 2'd1, 2'd2, 16'h4b00};
        rows[1] = '{24'h000003, 2'd1, 2'd2, 16'h5000};
        rows[2] = '{24'h000001, 2'd1, 2'd1, 16'h0000};
        rows[3] = '{24'h341203, 2'd3, 2'd2, 16'h1230};
        rows[4] = '{24'h5ffe02, 2'd3, 2'd2, 16'hfe50};
        rows[5] = '{24'h001801, 2'd2, 2'd1, 16'h0018};
        // Three edges so the pin synchronisers fill
        repeat (3) @(posedge clk_sys);
        check("alert_rst", over_temp_output, 16'h1);
        check("power_rst", sensor_powered, 16'h0);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check("power_on", sensor_powered, 16'h1);
        foreach (rows[i])
        begin
            xfer(dev, 1'b0, rows[i].wn, rows[i].tx);
            xfer(dev, 1'b1, rows[i].rn, 24'h0);
            check("reg", rx, rows[i].exp);
        end
        $display("register rows done");
        for (int c = 0; c < 4; c++)
        begin
            pol = c[0];
            xfer(dev, 1'b0, 2'd2, {8'h00, 3'b000, 2'(c), pol, 2'b00, 8'h01});
            temp_value <= 16'hc900;
            wait_conv();
            wait_conv();
            repeat (3) @(posedge clk_sys);
            check("alert_idle", over_temp_output, 16'(!pol));
            temp_value <= 16'h2000;
            k = 0;
            while (k < 8)
            begin
                wait_conv();
                k++;
                repeat (3) @(posedge clk_sys);
                if (over_temp_output === pol) break;
            end
            check("fault_count", 16'(k), 16'(nf[c]));
        end
        $display("fault queue done");
        xfer(dev, 1'b0, 2'd2, 24'h000201);
        xfer(dev, 1'b1, 2'd1, 24'h0);
        temp_value <= 16'hc900;
        wait_conv();
        temp_value <= 16'h2000;
        wait_conv();
        repeat (3) @(posedge clk_sys);
        check("latch_set", over_temp_output, 16'h0);
        xfer(dev, 1'b1, 2'd1, 24'h0);
        wait_conv();
        wait_conv();
        repeat (3) @(posedge clk_sys);
        check("latch_clear", over_temp_output, 16'h1);
        $display("latched mode done");
        xfer(dev, 1'b0, 2'd2, 24'h000101);
        repeat (5) @(posedge clk_sys);
        check("shdn_power", sensor_powered, 16'h0);
        k = n_conv;
        repeat (600) @(posedge clk_sys);
        check("shdn_conv", 16'(n_conv - k), 16'h0);
        xfer(dev, 1'b0, 2'd2, 24'h002001);
        k = n_conv;
        xfer(dev, 1'b0, 2'd1, 24'h000004);
        repeat (600) @(posedge clk_sys);
        check("oneshot_conv", 16'(n_conv - k), 16'h1);
        check("oneshot_power", sensor_powered, 16'h0);
        xfer(dev, 1'b0, 2'd2, 24'h000001);
        wait_conv();
        k = 0;
        do begin @(posedge clk_sys); k++; end while (conv_strobe !== 1'b1);
        check("conv_period", 16'(k), 16'd200);
        $display("power modes done");
        xfer(7'h50, 1'b1, 2'd1, 24'h0);
        check("foreign_addr", nk, 16'h1);
        asel <= 3'h5;
        xfer(7'h4d, 1'b1, 2'd1, 24'h0);
        check("pin_addr", nk, 16'h0);
        xfer(7'h48, 1'b1, 2'd1, 24'h0);
        check("old_addr", nk, 16'h1);
        $display("address pins done");
        final_report();
    end
endmodule : temp_sensor_config_limits_serial_slave_tb_top
